//--- hw/edw_write_ext.sv
// Purpose: Device side of the extended DMA write commands
// Assumes: Task-file strobes are synchronous one-cycle pulses
// Notes: Media reports one write result per sector
// Function
// - Opcode 35h passes words to media as taken; status after media done
// - FUA opcode reports status only after media done
// - Data moves as 16-bit words
// - Each word gated by device DMA request
// - Exactly one interrupt after transfer and status
// - Unrecoverable error stops write at failing sector
// - 16-bit count; zero means 65,536 sectors
// - 48-bit LBA from current and previous bytes
// - Failing LBA returned; HOB selects high bytes
`include "edw_map.svh"
`timescale 1ns/1ns
`default_nettype none
module edw_write_ext (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire edw_pkg::edw_bus_s i_bus,
    input wire logic i_hob,
    input wire logic i_drive_id,
    input wire logic [15:0] i_dma_data,
    input wire logic i_dma_ack,
    input wire logic i_dma_crc_err,
    input wire logic i_media_ready,
    input wire logic i_media_done,
    input wire logic i_media_fail,
    input wire logic i_write_cache_en,
    output logic [7:0] o_rdata,
    output logic o_dma_req,
    output logic o_intrq,
    output edw_pkg::edw_media_s o_media
);
    ////////////////////////////////////////////////////////////////
    edw_pkg::edw_state_e state;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] sec_cur;
    logic [7:0] sec_prev;
    logic [7:0] cyl_lo_cur;
    logic [7:0] cyl_lo_prev;
    logic [7:0] cyl_hi_cur;
    logic [7:0] cyl_hi_prev;
    logic [7:0] dev_head;
    logic [7:0] command_error_flags;
    logic [7:0] device_condition_flags;
    logic [16:0] sectors_left;
    logic [16:0] sectors_pending;
    logic [8:0] word_cnt;
    logic [47:0] cur_lba;
    logic [47:0] commit_lba;
    logic fua;
    logic ack_seen;
    logic accept;
    logic fail;
    logic finish;
    logic [7:0] fail_err;

    function automatic logic [7:0] pick(input logic hob,
            input logic [7:0] lo, input logic [7:0] hi);
        pick = hob ? hi : lo;
    endfunction : pick

    function automatic logic wr_at(input edw_pkg::edw_bus_s b,
            input logic [2:0] a);
        wr_at = b.wr && (b.addr == a);
    endfunction : wr_at

    ////////////////////////////////////////////////////////////////
    // Command acceptance
    assign accept = i_ce && state == edw_pkg::ST_IDLE
        && wr_at(i_bus, `EDW_ADDR_CMD)
        && (i_bus.wdata == `EDW_OP_WRITE_EXT
        || i_bus.wdata == `EDW_OP_WRITE_FUA)
        && dev_head[`EDW_DEV_LBA_BIT]
        && dev_head[`EDW_DEV_DRV_BIT] == i_drive_id;

    // Task-file shadow registers
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cnt_cur <= 8'h00;
            cnt_prev <= 8'h00;
            sec_cur <= 8'h00;
            sec_prev <= 8'h00;
            cyl_lo_cur <= 8'h00;
            cyl_lo_prev <= 8'h00;
            cyl_hi_cur <= 8'h00;
            cyl_hi_prev <= 8'h00;
            dev_head <= 8'h00;
        end else if (i_ce) begin
            if (fail) begin
                sec_cur <= cur_lba[7:0];
                cyl_lo_cur <= cur_lba[15:8];
                cyl_hi_cur <= cur_lba[23:16];
                sec_prev <= cur_lba[31:24];
                cyl_lo_prev <= cur_lba[39:32];
                cyl_hi_prev <= cur_lba[47:40];
            end else if (state == edw_pkg::ST_IDLE && i_bus.wr) begin
                if (i_bus.addr == `EDW_ADDR_COUNT) begin
                    cnt_prev <= cnt_cur;
                    cnt_cur <= i_bus.wdata;
                end else if (i_bus.addr == `EDW_ADDR_SECTOR) begin
                    sec_prev <= sec_cur;
                    sec_cur <= i_bus.wdata;
                end else if (i_bus.addr == `EDW_ADDR_CYL_LO) begin
                    cyl_lo_prev <= cyl_lo_cur;
                    cyl_lo_cur <= i_bus.wdata;
                end else if (i_bus.addr == `EDW_ADDR_CYL_HI) begin
                    cyl_hi_prev <= cyl_hi_cur;
                    cyl_hi_cur <= i_bus.wdata;
                end else if (i_bus.addr == `EDW_ADDR_DEVHEAD) begin
                    dev_head <= i_bus.wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer
    assign fail = i_ce && (
        (state == edw_pkg::ST_XFER && i_dma_ack && i_dma_crc_err)
        || ((state == edw_pkg::ST_XFER || state == edw_pkg::ST_COMMIT)
        && i_media_done && i_media_fail));
    assign fail_err = (state == edw_pkg::ST_XFER && i_dma_ack
        && i_dma_crc_err) ? (8'h01 << `EDW_ERR_CRC_BIT)
        : (8'h01 << `EDW_ERR_ADDR_NOT_FOUND_BIT);
    assign ack_seen = i_ce && state == edw_pkg::ST_XFER && i_dma_ack
        && o_dma_req && !i_dma_crc_err;
    assign finish = i_ce && !fail && sectors_pending == 17'h00000
        && sectors_left == 17'h00000
        && (state == edw_pkg::ST_COMMIT
        || (state == edw_pkg::ST_XFER && !fua && i_write_cache_en));

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state <= edw_pkg::ST_IDLE;
            fua <= 1'b0;
            sectors_left <= 17'h00000;
            word_cnt <= 9'h000;
            cur_lba <= 48'h0;
        end else if (i_ce) begin
            case (state)
            edw_pkg::ST_IDLE: begin
                if (accept) begin
                    state <= edw_pkg::ST_XFER;
                    fua <= (i_bus.wdata == `EDW_OP_WRITE_FUA);
                    sectors_left <= ({cnt_prev, cnt_cur} == 16'h0000)
                        ? 17'h10000 : {1'b0, cnt_prev, cnt_cur};
                    cur_lba <= {cyl_hi_prev, cyl_lo_prev, sec_prev,
                        cyl_hi_cur, cyl_lo_cur, sec_cur};
                    word_cnt <= 9'h000;
                end
            end
            edw_pkg::ST_XFER: begin
                if (fail) begin
                    state <= edw_pkg::ST_DONE;
                end else if (finish) begin
                    state <= edw_pkg::ST_DONE;
                end else if (sectors_left == 17'h00000) begin
                    state <= edw_pkg::ST_COMMIT;
                end else if (ack_seen) begin
                    if (word_cnt == `EDW_WORDS_PER_SECTOR - 9'h001) begin
                        word_cnt <= 9'h000;
                        sectors_left <= sectors_left - 17'h00001;
                    end else begin
                        word_cnt <= word_cnt + 9'h001;
                    end
                end
                if (!fail && i_media_done) begin
                    cur_lba <= cur_lba + 48'h1;
                end
            end
            edw_pkg::ST_COMMIT: begin
                if (fail || finish) begin
                    state <= edw_pkg::ST_DONE;
                end
                if (!fail && i_media_done) begin
                    cur_lba <= cur_lba + 48'h1;
                end
            end
            edw_pkg::ST_DONE: begin
                state <= edw_pkg::ST_IDLE;
            end
            default: state <= edw_pkg::ST_IDLE;
            endcase
        end
    end

    // Sectors sent to media and not yet acknowledged
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sectors_pending <= 17'h00000;
        end else if (i_ce) begin
            if (accept || fail) begin
                sectors_pending <= 17'h00000;
            end else if (ack_seen && word_cnt ==
                    `EDW_WORDS_PER_SECTOR - 9'h001 && !i_media_done) begin
                sectors_pending <= sectors_pending + 17'h00001;
            end else if (!(ack_seen && word_cnt ==
                    `EDW_WORDS_PER_SECTOR - 9'h001) && i_media_done
                    && sectors_pending != 17'h00000) begin
                sectors_pending <= sectors_pending - 17'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // DMA request and media words
    assign o_dma_req = state == edw_pkg::ST_XFER
        && sectors_left != 17'h00000 && i_media_ready;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_media <= '0;
        end else if (i_ce) begin
            o_media.valid <= ack_seen;
            o_media.data <= i_dma_data;
            o_media.lba <= commit_lba;
        end
    end

    // Media LBA of the sector being filled
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            commit_lba <= 48'h0;
        end else if (i_ce) begin
            if (accept) begin
                commit_lba <= {cyl_hi_prev, cyl_lo_prev, sec_prev,
                    cyl_hi_cur, cyl_lo_cur, sec_cur};
            end else if (ack_seen
                    && word_cnt == `EDW_WORDS_PER_SECTOR - 9'h001) begin
                commit_lba <= commit_lba + 48'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status, error and interrupt
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            command_error_flags <= 8'h00;
            device_condition_flags <= `EDW_STATUS_IDLE;
            o_intrq <= 1'b0;
        end else if (i_ce) begin
            if (state == edw_pkg::ST_IDLE && i_bus.wr
                    && i_bus.addr == `EDW_ADDR_CMD) begin
                if (accept) begin
                    command_error_flags <= 8'h00;
                    device_condition_flags <= 8'h01 << `EDW_ST_BUSY_BIT;
                    o_intrq <= 1'b0;
                end else begin
                    command_error_flags <= 8'h01 << `EDW_ERR_ABORT_BIT;
                    device_condition_flags <= `EDW_STATUS_IDLE
                        | (8'h01 << `EDW_ST_ERR_BIT);
                    o_intrq <= 1'b1;
                end
            end else if (fail) begin
                command_error_flags <= fail_err;
                device_condition_flags <= `EDW_STATUS_IDLE
                    | (8'h01 << `EDW_ST_ERR_BIT);
                o_intrq <= 1'b1;
            end else if (finish) begin
                device_condition_flags <= `EDW_STATUS_IDLE;
                o_intrq <= 1'b1;
            end else if (i_bus.rd && i_bus.addr == `EDW_ADDR_CMD) begin
                o_intrq <= 1'b0;
            end
        end
    end

    // Register read mux
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_bus.addr == `EDW_ADDR_ERROR) begin
                o_rdata <= command_error_flags;
            end else if (i_bus.addr == `EDW_ADDR_COUNT) begin
                o_rdata <= pick(i_hob, cnt_cur, cnt_prev);
            end else if (i_bus.addr == `EDW_ADDR_SECTOR) begin
                o_rdata <= pick(i_hob, sec_cur, sec_prev);
            end else if (i_bus.addr == `EDW_ADDR_CYL_LO) begin
                o_rdata <= pick(i_hob, cyl_lo_cur, cyl_lo_prev);
            end else if (i_bus.addr == `EDW_ADDR_CYL_HI) begin
                o_rdata <= pick(i_hob, cyl_hi_cur, cyl_hi_prev);
            end else if (i_bus.addr == `EDW_ADDR_DEVHEAD) begin
                o_rdata <= dev_head;
            end else if (i_bus.addr == `EDW_ADDR_CMD) begin
                o_rdata <= device_condition_flags;
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end
endmodule : edw_write_ext
`default_nettype wire

//--- include/edw_map.svh
// Purpose: Constants for the extended DMA write command block
// Assumes: Task-file register addresses as on a parallel ATA port
// Notes: Byte offsets are task-file addresses, not bus bytes
`ifndef EDW_MAP_SVH
`define EDW_MAP_SVH
`define EDW_ADDR_DATA 3'h0
`define EDW_ADDR_ERROR 3'h1
`define EDW_ADDR_COUNT 3'h2
`define EDW_ADDR_SECTOR 3'h3
`define EDW_ADDR_CYL_LO 3'h4
`define EDW_ADDR_CYL_HI 3'h5
`define EDW_ADDR_DEVHEAD 3'h6
`define EDW_ADDR_CMD 3'h7
`define EDW_OP_WRITE_EXT 8'h35
`define EDW_OP_WRITE_FUA 8'h3d
`define EDW_DEV_LBA_BIT 6
`define EDW_DEV_DRV_BIT 4
`define EDW_CTL_HOB_BIT 7
`define EDW_ERR_CRC_BIT 7
`define EDW_ERR_ADDR_NOT_FOUND_BIT 4
`define EDW_ERR_ABORT_BIT 2
`define EDW_ST_BUSY_BIT 7
`define EDW_ST_READY_BIT 6
`define EDW_ST_SEEK_BIT 4
`define EDW_ST_DRQ_BIT 3
`define EDW_ST_ERR_BIT 0
`define EDW_WORDS_PER_SECTOR 9'h100
`define EDW_STATUS_IDLE 8'h50
`endif

//--- include/edw_pkg.sv
// Purpose: Types for the extended DMA write command block
// Assumes: Used with edw_map.svh
// Notes: Structs carry task-file and media signals
package edw_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_XFER, ST_COMMIT, ST_DONE
    } edw_state_e;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } edw_bus_s;
    typedef struct packed {
        logic [47:0] lba;
        logic [15:0] data;
        logic valid;
    } edw_media_s;
endpackage : edw_pkg

//--- testbench/edw_host_dma.sv
// Purpose: Host slave-DMA channel model
// Assumes: Words change just after a rising edge
// Notes: Random stalls and CRC marking on request
`timescale 1ns/1ns
`default_nettype none
module edw_host_dma (
    input wire logic i_clk_sys,
    input wire logic i_ce,
    input wire logic i_dma_req,
    input wire logic i_stall_en,
    input wire logic i_crc_mode,
    output logic o_dma_ack,
    output logic [15:0] o_dma_data,
    output logic o_dma_crc_err
);
    logic go;
    initial begin
        o_dma_ack = 1'b0;
        o_dma_data = 16'h0;
        o_dma_crc_err = 1'b0;
    end
    // Word held until taken under request
    always @(posedge i_clk_sys) begin
        if (!o_dma_ack || (i_dma_req && i_ce)) begin
            go = !i_stall_en || ($urandom_range(2) != 0);
            o_dma_ack <= #1 go;
            o_dma_crc_err <= #1 go && i_crc_mode;
            o_dma_data <= #1 go ? 16'($urandom) : ~o_dma_data;
        end
    end
endmodule : edw_host_dma
`default_nettype wire

//--- testbench/edw_write_ext_props.sv
// Purpose: Port assertions for edw_write_ext
// Assumes: One clock domain
// Notes: Bound after the module
`include "edw_map.svh"
`timescale 1ns/1ns
`default_nettype none
module edw_write_ext_props (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire edw_pkg::edw_bus_s i_bus,
    input wire logic [15:0] i_dma_data,
    input wire logic i_dma_ack,
    input wire logic i_dma_crc_err,
    input wire logic i_media_ready,
    input wire logic o_dma_req,
    input wire logic o_intrq,
    input wire edw_pkg::edw_media_s o_media
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    logic tk;
    logic rd7;
    logic rc;
    assign tk = i_ce && i_dma_ack && o_dma_req && !i_dma_crc_err;
    assign rd7 = i_ce && i_bus.addr == `EDW_ADDR_CMD;
    assign rc = i_reset && i_ce;
    property p_rst;
        $past(rc) |-> !o_intrq && !o_dma_req && !o_media.valid;
    endproperty
    a_rst: assert property (p_rst) else $error("reset left outputs set");
    property p_take;
        tk |=> o_media.valid;
    endproperty
    a_take: assert property (p_take) else $error("word not sent");
    property p_data;
        tk |=> o_media.data == $past(i_dma_data);
    endproperty
    a_data: assert property (p_data) else $error("word changed");
    property p_cause;
        o_media.valid && $past(i_ce) |-> $past(tk);
    endproperty
    a_cause: assert property (p_cause) else $error("word unasked");
    property p_gate;
        o_dma_req |-> i_media_ready;
    endproperty
    a_gate: assert property (p_gate) else $error("request not ready");
    property p_end;
        $rose(o_intrq) |-> !o_dma_req;
    endproperty
    a_end: assert property (p_end) else $error("irq during transfer");
    property p_hold;
        o_intrq && !(rd7 && (i_bus.rd || i_bus.wr)) |=> o_intrq;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_clr;
        o_intrq && rd7 && i_bus.rd && !i_bus.wr |=> !o_intrq;
    endproperty
    a_clr: assert property (p_clr) else $error("irq not cleared");
    property p_frz;
        !i_ce |=> $stable(o_intrq) && $stable(o_media);
    endproperty
    a_frz: assert property (p_frz) else $error("state moved while frozen");
    c_done: cover property ($rose(o_intrq));
    c_stall: cover property (o_dma_req && !i_dma_ack);
    c_burst: cover property (tk ##1 tk);
endmodule : edw_write_ext_props
bind edw_write_ext edw_write_ext_props edw_write_ext_props_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce), .i_bus(i_bus),
    .i_dma_data(i_dma_data), .i_dma_ack(i_dma_ack),
    .i_dma_crc_err(i_dma_crc_err),
    .i_media_ready(i_media_ready), .o_dma_req(o_dma_req),
    .o_intrq(o_intrq), .o_media(o_media));
`default_nettype wire

//--- testbench/tb_edw_write_ext.sv
// Purpose: Self-checking bench for edw_write_ext
// Assumes: Host DMA model edw_host_dma
// Notes: Media path modelled here
`include "edw_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_edw_write_ext;
    logic i_clk_sys, rst, ce, hob, drv, rdy, mdone, mfail, cache, stall, crc;
    logic ack, dcrc, req, irq;
    logic [15:0] dat;
    logic [7:0] rdata, op;
    logic [47:0] lba0;
    edw_pkg::edw_bus_s bus;
    edw_pkg::edw_media_s med;
    logic [15:0] exp_q[$];
    int miscompares, samples_checked, cyc, words, dones, fail_at, dly, pend;
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    edw_write_ext edw_write_ext_i (.i_clk_sys(i_clk_sys), .i_reset(rst),
        .i_ce(ce), .i_bus(bus), .i_hob(hob), .i_drive_id(drv),
        .i_dma_data(dat), .i_dma_ack(ack), .i_dma_crc_err(dcrc),
        .i_media_ready(rdy), .i_media_done(mdone), .i_media_fail(mfail),
        .i_write_cache_en(cache), .o_rdata(rdata), .o_dma_req(req),
        .o_intrq(irq), .o_media(med));
    edw_host_dma edw_host_dma_i (.i_clk_sys(i_clk_sys), .i_ce(ce),
        .i_dma_req(req), .i_stall_en(stall), .i_crc_mode(crc),
        .o_dma_ack(ack), .o_dma_data(dat), .o_dma_crc_err(dcrc));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic ck(input string w, input logic [47:0] e,
        input logic [47:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask : ck
    // Media model and word checks
    always @(posedge i_clk_sys) begin
        cyc++;
        if (med.valid && exp_q.size() == 0) begin
            ck("extra word", 48'h1, 48'h0);
        end
        if (med.valid && exp_q.size() > 0) begin
            ck("data", 48'(exp_q.pop_front()), 48'(med.data));
            ck("lba", lba0 + 48'(words / 256), med.lba);
            words++;
            pend += (words % 256 == 0);
        end
        if (ack && req && ce) exp_q.push_back(dat);
        if (pend > 0 && dly == 0) begin
            mdone <= #1 1'b1;
            mfail <= #1 (dones == fail_at);
            dones++;
            pend--;
            dly = 30;
        end else begin
            mdone <= #1 1'b0;
            mfail <= #1 1'b0;
            dly -= (pend > 0 && dly > 0);
        end
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) #1;
        bus.addr = a;
        bus.wdata = d;
        bus.wr = 1'b1;
        @(posedge i_clk_sys) #1;
        bus.wr = 1'b0;
    endtask : wr
    task automatic rr(input string w, input logic [2:0] a, input logic h,
        input logic [7:0] m, input logic [7:0] e);
        @(posedge i_clk_sys) #1;
        bus.addr = a;
        bus.rd = 1'b1;
        hob = h;
        @(posedge i_clk_sys) #1;
        bus.rd = 1'b0;
        ck(w, 48'(e), 48'(rdata & m));
    endtask : rr
    task automatic run(input logic [7:0] o, input logic [7:0] dh,
        input logic [15:0] n, input int f);
        words = 0;
        exp_q.delete();
        dones = 0;
        pend = 0;
        fail_at = f;
        dly = 30;
        wr(`EDW_ADDR_COUNT, n[15:8]);
        wr(`EDW_ADDR_COUNT, n[7:0]);
        for (int k = 3; k < 6; k++) begin
            wr(3'(`EDW_ADDR_SECTOR + k - 3), lba0[8 * k +: 8]);
            wr(3'(`EDW_ADDR_SECTOR + k - 3), lba0[8 * k - 24 +: 8]);
        end
        wr(`EDW_ADDR_DEVHEAD, dh);
        wr(`EDW_ADDR_CMD, o);
        for (int t = 0; t < 3000 && irq !== 1'b1; t++) @(posedge i_clk_sys);
        #1;
        ck("interrupt", 48'h1, 48'(irq));
    endtask : run
    task automatic fin();
        int w;
        w = words;
        repeat (100) @(posedge i_clk_sys);
        #1;
        ck("irq after read", 48'h0, 48'(irq));
        ck("words after end", 48'(w), 48'(words));
    endtask : fin
    initial begin
        void'($urandom(32'h759e));
        {rst, ce, rdy} = 3'b111;
        {hob, drv, mdone, mfail, cache, stall, crc} = 7'h0;
        bus = '0;
        lba0 = '0;
        repeat (2) @(posedge i_clk_sys);
        #1 rst = 1'b0;
        rr("idle status", `EDW_ADDR_CMD, 1'b0, 8'hff, `EDW_STATUS_IDLE);
        for (int i = 0; i < 4; i++) begin
            {cache, drv, stall} = {i[1], i[0], i[0]};
            op = i[0] ? `EDW_OP_WRITE_FUA : `EDW_OP_WRITE_EXT;
            lba0 = {16'($urandom), 32'hffff_ffff};
            run(op, {3'b010, drv, 4'h0}, 16'h0002, -1);
            // Frozen read of status must not clear the interrupt
            ce = 1'b0;
            bus.addr = `EDW_ADDR_CMD;
            bus.rd = 1'b1;
            repeat (3) @(posedge i_clk_sys);
            #1;
            {ce, bus.rd} = 2'b10;
            ck("irq frozen", 48'h1, 48'(irq));
            ck("words", 48'd512, 48'(words));
            if (op == `EDW_OP_WRITE_FUA || !cache) begin
                ck("done", 48'd2, 48'(dones));
            end
            rr("error", `EDW_ADDR_ERROR, 1'b0, 8'hff, 8'h00);
            rr("status", `EDW_ADDR_CMD, 1'b0, 8'hff, `EDW_STATUS_IDLE);
            fin();
        end
        {cache, drv} = 2'b00;
        lba0 = {16'($urandom), 32'($urandom)};
        run(`EDW_OP_WRITE_EXT, 8'h40, 16'h0002, 0);
        ck("stopped", 48'h1, 48'(words < 512));
        rr("fail cause", `EDW_ADDR_ERROR, 1'b0, 8'h10, 8'h10);
        for (int k = 0; k < 6; k++)
            rr("fail lba", 3'(3 + k % 3), 1'(k >= 3), 8'hff,
                lba0[8 * k +: 8]);
        rr("fail status", `EDW_ADDR_CMD, 1'b0, 8'h81, 8'h01);
        fin();
        crc = 1'b1;
        run(`EDW_OP_WRITE_EXT, 8'h40, 16'h0001, -1);
        crc = 1'b0;
        rr("crc cause", `EDW_ADDR_ERROR, 1'b0, 8'h80, 8'h80);
        rr("crc status", `EDW_ADDR_CMD, 1'b0, 8'h81, 8'h01);
        fin();
        for (int i = 0; i < 3; i++) begin
            op = (i == 0) ? {2'b11, 6'($urandom)} : `EDW_OP_WRITE_EXT;
            run(op, (i == 1) ? 8'h00 : (i == 2) ? 8'h50 : 8'h40, 16'h1,
                -1);
            ck("no words", 48'h0, 48'(words));
            rr("abort cause", `EDW_ADDR_ERROR, 1'b0, 8'h04, 8'h04);
            rr("abort status", `EDW_ADDR_CMD, 1'b0, 8'h81, 8'h01);
            fin();
        end
        stop_test();
    end
endmodule : tb_edw_write_ext
`default_nettype wire
